// ### logic/bit_manip_unit.sv
// Bit manipulation execution unit: carry logic, loads, stores and read-modify-write
module bit_manip_unit
   import bit_unit_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              srst,
   // Decoder side
   input  wire logic              start,
   input  wire logic [15:0]       first_word,
   input  wire logic [15:0]       second_word,
   input  wire logic [7:0]        opcode,
   input  wire bit_op_t           op,
   input  wire operand_mode_t     mode,
   input  wire logic              bit_from_reg,
   input  wire logic [7:0]        reg_operand,
   input  wire logic [7:0]        reg_bitnum,
   input  wire logic [15:0]       reg_pointer,
   input  wire logic              carry_in,
   // Results
   output logic                   done,
   output logic                   illegal,
   output logic                   carry_out,
   output logic                   carry_we,
   output logic                   zero_out,
   output logic                   zero_we,
   output logic [7:0]             reg_result,
   output logic                   reg_we,
   // Memory bus
   output logic [15:0]            mem_addr,
   output logic                   mem_rd,
   output logic                   mem_wr,
   output logic [7:0]             mem_wdata,
   input  wire logic [7:0]        mem_rdata,
   input  wire logic              mem_ack,
   input  wire logic              mem_write_only
);

   // ------------------------------------------------------------------
   // Classification helpers
   // ------------------------------------------------------------------
   function automatic logic is_rmw(bit_op_t o);
      return o inside {bit_set_op, bit_clear_op, bit_invert_op,
                       carry_store_to_bit, inverted_carry_store_to_bit};
   endfunction

   function automatic logic reg_bit_ok(bit_op_t o);
      return o inside {bit_set_op, bit_clear_op, bit_invert_op, bit_test_op};
   endfunction

   typedef enum {st_idle, st_read, st_write, st_done} state_t;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   state_t        state, next_state;
   bit_op_t       op_q, next_op_q;
   logic [2:0]    bitn, next_bitn;
   logic          cin, next_cin;
   logic [15:0]   addr, next_addr;
   logic [7:0]    wdata, next_wdata;
   logic          next_done, next_illegal, next_carry_out, next_carry_we;
   logic          next_zero_out, next_zero_we, next_reg_we, next_mem_rd, next_mem_wr;
   logic [7:0]    next_reg_result;

   logic [7:0]    operand;
   logic [7:0]    read_byte;
   logic          sel_bit, new_bit;
   logic [7:0]    mod_byte;
   logic [2:0]    imm_bit;
   logic          bad_form;
   bit_op_t       cur_op;
   logic          cur_cin;
   logic [2:0]    cur_bitn;

   bit_select u_sel (
      .byte_in  (operand),
      .bit_num  (cur_bitn),
      .new_bit  (new_bit),
      .sel_bit  (sel_bit),
      .byte_out (mod_byte)
   );

   // Write-only targets return all ones during the read phase
   assign read_byte = mem_write_only ? ALL_ONES : mem_rdata;
   assign operand   = (state == st_idle) ? reg_operand : read_byte;
   // Register-direct immediate sits in bits 6:4 of the word
   assign imm_bit   = (mode == mode_reg_direct) ? first_word[6:4] : second_word[6:4];
   // Register-direct results are made in the start cycle, before op_q, bitn and cin are loaded
   assign cur_op    = (state == st_idle) ? op : op_q;
   assign cur_cin   = (state == st_idle) ? carry_in : cin;
   assign cur_bitn  = (state == st_idle) ? (bit_from_reg ? reg_bitnum[2:0] : imm_bit) : bitn;

   always_comb begin
      unique case (cur_op)
         bit_set_op:                  new_bit = 1'b1;
         bit_clear_op:                new_bit = 1'b0;
         bit_invert_op:               new_bit = ~sel_bit;
         carry_store_to_bit:          new_bit = cur_cin;
         inverted_carry_store_to_bit: new_bit = ~cur_cin;
         default:                     new_bit = sel_bit;
      endcase
      // Inverted and carry-logic forms refuse a register bit number;
      // two-word forms need a zero low nibble in the operation word
      bad_form = (mode == mode_bad)
               || (bit_from_reg && !reg_bit_ok(op))
               || (mode != mode_reg_direct && second_word[3:0] != LOW_NIBBLE_0)
               || (op inside {op_none0, op_none1});
   end

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   always_comb begin
      next_state      = state;
      next_op_q       = op_q;
      next_bitn       = bitn;
      next_cin        = cin;
      next_addr       = addr;
      next_wdata      = wdata;
      next_done       = 1'b0;
      next_illegal    = 1'b0;
      next_carry_out  = carry_out;
      next_carry_we   = 1'b0;
      next_zero_out   = zero_out;
      next_zero_we    = 1'b0;
      next_reg_we     = 1'b0;
      next_reg_result = reg_result;
      next_mem_rd     = 1'b0;
      next_mem_wr     = 1'b0;
      unique case (state)
         st_idle: if (start) begin
            next_op_q = op;
            next_cin  = carry_in;
            next_bitn = bit_from_reg ? reg_bitnum[2:0] : imm_bit;
            // In absolute mode the first word addresses the operand, otherwise reg_pointer does; second holds the operation
            next_addr = (mode == mode_absolute) ? {ABS_PAGE, first_word[7:0]} : reg_pointer;
            if (bad_form) begin
               next_illegal = 1'b1;
               next_done    = 1'b1;
            end else if (mode == mode_reg_direct) begin
               next_state = st_done;
            end else begin
               next_mem_rd = 1'b1;
               next_state  = st_read;
            end
            opcode_unused_sink(opcode);
         end
         st_read: begin
            next_mem_rd = ~mem_ack;
            if (mem_ack) begin
               next_wdata = mod_byte;
               next_state = is_rmw(op_q) ? st_write : st_done;
               next_mem_wr = is_rmw(op_q);
            end
         end
         st_write: begin
            next_mem_wr = ~mem_ack;
            if (mem_ack) begin
               next_state = st_idle;
               next_done  = 1'b1;
            end
         end
         st_done: begin
            next_state = st_idle;
            next_done  = 1'b1;
         end
      endcase
      // Flag and register results are produced from the operand in hand
      if ((state == st_idle && start && !bad_form && mode == mode_reg_direct) ||
          (state == st_read && mem_ack)) begin
         if (state == st_idle) begin
            next_reg_result = mod_byte;
            next_reg_we     = is_rmw(cur_op);
         end
         unique case (cur_op)
            carry_and_bit:              begin next_carry_out = cur_cin & sel_bit;  next_carry_we = 1'b1; end
            carry_or_bit:               begin next_carry_out = cur_cin | sel_bit;  next_carry_we = 1'b1; end
            carry_xor_bit:              begin next_carry_out = cur_cin ^ sel_bit;  next_carry_we = 1'b1; end
            carry_and_inverted_bit:     begin next_carry_out = cur_cin & ~sel_bit; next_carry_we = 1'b1; end
            carry_or_inverted_bit:      begin next_carry_out = cur_cin | ~sel_bit; next_carry_we = 1'b1; end
            carry_xor_inverted_bit:     begin next_carry_out = cur_cin ^ ~sel_bit; next_carry_we = 1'b1; end
            bit_load_to_carry:          begin next_carry_out = sel_bit;        next_carry_we = 1'b1; end
            inverted_bit_load_to_carry: begin next_carry_out = ~sel_bit;       next_carry_we = 1'b1; end
            bit_test_op:                begin next_zero_out  = ~sel_bit;       next_zero_we  = 1'b1; end
            default:                    ;
         endcase
      end
   end

   function automatic void opcode_unused_sink(logic [7:0] o);
   endfunction

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state      <= st_idle;
         op_q       <= bit_set_op;
         bitn       <= '0;
         cin        <= 1'b0;
         addr       <= '0;
         wdata      <= '0;
         done       <= 1'b0;
         illegal    <= 1'b0;
         carry_out  <= 1'b0;
         carry_we   <= 1'b0;
         zero_out   <= 1'b0;
         zero_we    <= 1'b0;
         reg_we     <= 1'b0;
         reg_result <= '0;
         mem_rd     <= 1'b0;
         mem_wr     <= 1'b0;
      end else begin
         state      <= next_state;
         op_q       <= next_op_q;
         bitn       <= next_bitn;
         cin        <= next_cin;
         addr       <= next_addr;
         wdata      <= next_wdata;
         done       <= next_done;
         illegal    <= next_illegal;
         carry_out  <= next_carry_out;
         carry_we   <= next_carry_we;
         zero_out   <= next_zero_out;
         zero_we    <= next_zero_we;
         reg_we     <= next_reg_we;
         reg_result <= next_reg_result;
         mem_rd     <= next_mem_rd;
         mem_wr     <= next_mem_wr;
      end
   end

   assign mem_addr  = addr;
   assign mem_wdata = wdata;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_rmw_writeback: assert property (@(posedge ref_clk) disable iff (srst)
      (state == st_read && mem_ack && is_rmw(op_q)) |=> (mem_wr && mem_addr == $past(addr)))
      else $error("read-modify-write did not write back to same address");
   a_write_only_ones: assert property (@(posedge ref_clk) disable iff (srst)
      (state == st_read && mem_ack && mem_write_only && is_rmw(op_q)) |=>
         ((mem_wdata | (8'h01 << bitn)) == ALL_ONES))
      else $error("write-only target not written back as ones");
   a_clear_bit_zero: assert property (@(posedge ref_clk) disable iff (srst)
      (state == st_write && op_q == bit_clear_op) |-> !mem_wdata[bitn])
      else $error("cleared bit not zero");
   a_store_carry: assert property (@(posedge ref_clk) disable iff (srst)
      (state == st_write && op_q == carry_store_to_bit) |-> mem_wdata[bitn] == cin)
      else $error("store did not place carry");
   a_inv_store: assert property (@(posedge ref_clk) disable iff (srst)
      (state == st_write && op_q == inverted_carry_store_to_bit) |-> mem_wdata[bitn] != cin)
      else $error("inverted store wrong");
   a_load_no_write: assert property (@(posedge ref_clk) disable iff (srst)
      (state == st_read && op_q == bit_load_to_carry && mem_ack) |=> (carry_we && !mem_wr))
      else $error("bit load wrote memory or missed carry");
   a_test_zero: assert property (@(posedge ref_clk) disable iff (srst)
      (state == st_read && mem_ack && op_q == bit_test_op) |=> (zero_we && zero_out == !$past(sel_bit)))
      else $error("bit test zero flag wrong");
   a_reg_bitnum_ok: assert property (@(posedge ref_clk) disable iff (srst)
      (state == st_idle && start && bit_from_reg && !reg_bit_ok(op)) |=> (illegal && done))
      else $error("register bit number accepted for immediate-only op");
endmodule

// ### logic/bit_select.sv
// Single-bit extract and replace helper for one byte
module bit_select
   import bit_unit_pkg::*;
(
   input  wire logic [7:0] byte_in,
   input  wire logic [2:0] bit_num,
   input  wire logic       new_bit,
   output logic            sel_bit,
   output logic [7:0]      byte_out
);
   always_comb begin
      sel_bit           = byte_in[bit_num];
      byte_out          = byte_in;
      byte_out[bit_num] = new_bit;
   end
endmodule

// ### logic/bit_unit_pkg.sv
// Constants and types shared by the bit manipulation unit
// How it works
// - Inverted carry XOR: carry becomes old carry XOR not selected bit.
// - Bit load copies the selected operand bit into carry, operand untouched.
// - Inverted bit load puts the complement of the selected bit into carry.
// - Carry store writes carry into the selected bit, other seven bits kept.
// - Inverted carry store writes not carry into the selected bit.
// - Inverted-operand instructions take the bit number only from the immediate field.
// - Set, clear, invert, store forms read a byte, change one bit, write back.
// - A write-only target reads as all ones, so other bits are written as ones.
// - Set, clear, invert, test accept immediate or register bit number, three operand modes.
// - Carry logic, load and store take immediate bit number only, three operand modes.
// - Inverted carry logic, load and store support the three operand modes with immediate.
// - A register bit number uses only its three least significant bits.
// - Bit test sets zero flag to the complement of the selected bit.
// - Bit clear forces the selected bit to zero.
// - Bit invert replaces the selected bit with its complement.
package bit_unit_pkg;
   typedef enum logic [3:0] {
      bit_set_op, bit_clear_op, bit_invert_op, bit_test_op,
      carry_and_bit, carry_or_bit, carry_xor_bit,
      carry_and_inverted_bit, carry_or_inverted_bit, carry_xor_inverted_bit,
      bit_load_to_carry, inverted_bit_load_to_carry,
      carry_store_to_bit, inverted_carry_store_to_bit,
      op_none0, op_none1
   } bit_op_t;

   typedef enum logic [1:0] {
      mode_reg_direct, mode_reg_indirect, mode_absolute, mode_bad
   } operand_mode_t;

   localparam int           BIT_NUM_W     = 3;
   localparam int           BYTE_W        = 8;
   localparam int           ADDR_W        = 16;
   localparam logic [7:0]   ALL_ONES      = 8'hff;
   localparam logic [15:8]  ABS_PAGE      = 8'hff;
   localparam logic [3:0]   LOW_NIBBLE_0  = 4'h0;
endpackage

// ### tb/mem_model.sv
// Behavioural memory and register space on the bit unit's bus
module mem_model
   import bit_unit_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic [15:0] mem_addr,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic [7:0]  mem_wdata,
   input  wire logic [3:0]  wait_cycles,
   input  wire logic [15:0] wo_addr,
   output logic [7:0]       mem_rdata,
   output logic             mem_ack,
   output logic             mem_write_only
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   logic [3:0] waited = 4'h0;
   initial mem_ack = 1'b0;
   initial mem_rdata = 8'h00;
   // A write-only place hides its contents; the unit must read it as all ones
   assign mem_write_only = (mem_addr === wo_addr);
   always @(posedge ref_clk) begin
      mem_ack <= 1'b0;
      // Read data is only valid in the acknowledge cycle, otherwise it toggles
      mem_rdata <= ~mem_rdata;
      if ((mem_rd === 1'b1 || mem_wr === 1'b1) && !mem_ack) begin
         if (waited < wait_cycles) waited <= waited + 4'h1;
         else begin
            waited <= 4'h0;
            mem_ack <= 1'b1;
            if (mem_rd) mem_rdata <= mem[mem_addr[7:0]];
            else mem[mem_addr[7:0]] <= mem_wdata;
         end
      end
   end
endmodule

// ### tb/tb_bit_manip_unit.sv
// Self-checking bench for the bit manipulation unit
module tb_bit_manip_unit
   import bit_unit_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic          ref_clk = 1'b0, srst = 1'b1, start = 1'b0, bfr = 1'b0, cin = 1'b0;
   bit_op_t       op = bit_set_op;
   operand_mode_t mode = mode_reg_direct;
   logic [15:0]   fw = 16'h0000, sw = 16'h0000, ptr = 16'h1240, wo = 16'hff90, ma;
   logic [7:0]    rop = 8'h00, rbn = 8'h00, mrd, wd, rres, cr;
   logic [7:0]    cnt [5];
   logic [3:0]    wt = 4'h0, nib = 4'h0;
   logic          done, ill, co, cwe, zo, zwe, rwe, mr, mw, ack, wonly, cc, cz;
   int            errors = 0, total_checks = 0;

   always #20 ref_clk = ~ref_clk;

   bit_manip_unit u_bit_manip_unit (.ref_clk(ref_clk), .srst(srst), .start(start), .first_word(fw),
      .second_word(sw), .opcode(8'h00), .op(op), .mode(mode), .bit_from_reg(bfr), .reg_operand(rop),
      .reg_bitnum(rbn), .reg_pointer(ptr), .carry_in(cin), .done(done), .illegal(ill), .carry_out(co),
      .carry_we(cwe), .zero_out(zo), .zero_we(zwe), .reg_result(rres), .reg_we(rwe), .mem_addr(ma),
      .mem_rd(mr), .mem_wr(mw), .mem_wdata(wd), .mem_rdata(mrd), .mem_ack(ack), .mem_write_only(wonly));
   mem_model u_mem_model (.ref_clk(ref_clk), .mem_addr(ma), .mem_rd(mr), .mem_wr(mw), .mem_wdata(wd),
      .wait_cycles(wt), .wo_addr(wo), .mem_rdata(mrd), .mem_ack(ack), .mem_write_only(wonly));

   // Pulses are one cycle wide, so they are counted on every rising edge
   always @(posedge ref_clk) begin
      if (cwe === 1'b1) begin cnt[0]++; cc = co; end
      if (zwe === 1'b1) begin cnt[1]++; cz = zo; end
      if (rwe === 1'b1) begin cnt[2]++; cr = rres; end
      if (mr === 1'b1 && ack === 1'b1) cnt[3]++;
      if (mw === 1'b1 && ack === 1'b1) cnt[4]++;
   end

   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   function automatic void ref_op(bit_op_t o, logic [7:0] d, logic [2:0] n, logic c, output logic ec,
                                  output logic ecw, output logic ezw, output logic erw, output logic [7:0] r);
      logic s;
      s = d[n];
      r = d;
      ec = c;
      ecw = (o >= carry_and_bit && o <= inverted_bit_load_to_carry);
      ezw = (o == bit_test_op);
      erw = o inside {bit_set_op, bit_clear_op, bit_invert_op, carry_store_to_bit, inverted_carry_store_to_bit};
      case (o)
         bit_set_op:                  r[n] = 1'b1;
         bit_clear_op:                r[n] = 1'b0;
         bit_invert_op:               r[n] = ~s;
         carry_store_to_bit:          r[n] = c;
         inverted_carry_store_to_bit: r[n] = ~c;
         carry_and_bit:               ec = c & s;
         carry_or_bit:                ec = c | s;
         carry_xor_bit:               ec = c ^ s;
         carry_and_inverted_bit:      ec = c & ~s;
         carry_or_inverted_bit:       ec = c | ~s;
         carry_xor_inverted_bit:      ec = c ^ ~s;
         bit_load_to_carry:           ec = s;
         inverted_bit_load_to_carry:  ec = ~s;
         default:                     ;
      endcase
   endfunction

   // Bit number in the immediate field is the complement of n when the register supplies it
   task automatic exec(bit_op_t o, operand_mode_t m, logic [2:0] n, logic b, logic [7:0] d, logic c, logic e,
                       logic [7:0] a);
      logic [7:0] ed, eb, idx;
      logic       ec, ecw, ezw, erw, mem;
      int         k;
      mem = (m != mode_reg_direct);
      idx = (m == mode_absolute) ? a : ptr[7:0];
      ed = (m == mode_absolute && {8'hff, a} == wo) ? 8'hff : d;
      @(negedge ref_clk);
      cnt = '{default: 8'h00};
      u_mem_model.mem[idx] = d;
      op = o;
      mode = m;
      bfr = b;
      cin = c;
      rop = d;
      rbn = {5'b10101, n};
      fw = {8'h00, (m == mode_reg_direct) ? {1'b0, b ? ~n : n, 4'h3} : a};
      sw = {9'h000, b ? ~n : n, nib};
      start = 1'b1;
      @(negedge ref_clk);
      start = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 100) begin
         @(negedge ref_clk);
         k++;
      end
      ref_op(o, ed, n, c, ec, ecw, ezw, erw, eb);
      check("done", 8'(done), 8'h01);
      check("illegal", 8'(ill), 8'(e));
      check("carry writes", cnt[0], 8'(!e && ecw));
      if (!e && ecw) check("carry", 8'(cc), 8'(ec));
      check("zero writes", cnt[1], 8'(!e && ezw));
      if (!e && ezw) check("zero", 8'(cz), 8'(!ed[n]));
      check("reg writes", cnt[2], 8'(!e && erw && !mem));
      check("reads", cnt[3], 8'(!e && mem));
      check("writes", cnt[4], 8'(!e && erw && mem));
      if (!e && erw) check("result", mem ? u_mem_model.mem[idx] : cr, eb);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reg_direct();
      for (int i = 0; i < 56; i++)
         exec(bit_op_t'(i / 4), mode_reg_direct, 3'(2 * (i % 4) + 1), 1'b0, 8'h5a, 1'(i % 2), 1'b0, 8'h00);
      $display("test reg_direct done");
   endtask

   task automatic t_memory();
      for (int i = 0; i < 56; i++) begin
         wt = (i % 3 == 0) ? 4'h3 : 4'h0;
         exec(bit_op_t'(i % 14), (i < 28) ? mode_reg_indirect : mode_absolute, ((i / 14) % 2) ? 3'h7 : 3'h2,
              1'b0, 8'h80, 1'(i / 28), 1'b0, 8'h20);
      end
      $display("test memory done");
   endtask

   task automatic t_reg_bitnum();
      for (int i = 0; i < 12; i++)
         exec(bit_op_t'(i % 4), operand_mode_t'(i / 4), 3'(i), 1'b1, 8'hc3, 1'b0, 1'b0, 8'h20);
      $display("test reg_bitnum done");
   endtask

   task automatic t_write_only();
      exec(bit_clear_op, mode_absolute, 3'h0, 1'b0, 8'h3f, 1'b0, 1'b0, 8'h90);
      check("write-only byte", u_mem_model.mem[8'h90], 8'hfe);
      exec(carry_store_to_bit, mode_absolute, 3'h3, 1'b0, 8'h00, 1'b0, 1'b0, 8'h90);
      exec(inverted_carry_store_to_bit, mode_absolute, 3'h5, 1'b0, 8'h00, 1'b1, 1'b0, 8'h90);
      exec(bit_test_op, mode_absolute, 3'h6, 1'b0, 8'h00, 1'b0, 1'b0, 8'h90);
      $display("test write_only done");
   endtask

   task automatic t_illegal();
      exec(carry_xor_inverted_bit, mode_reg_direct, 3'h1, 1'b1, 8'h02, 1'b0, 1'b1, 8'h00);
      exec(carry_store_to_bit, mode_reg_indirect, 3'h1, 1'b1, 8'h02, 1'b0, 1'b1, 8'h00);
      nib = 4'h8;
      exec(bit_set_op, mode_reg_indirect, 3'h2, 1'b0, 8'h00, 1'b0, 1'b1, 8'h00);
      nib = 4'h0;
      exec(bit_set_op, mode_bad, 3'h2, 1'b0, 8'h00, 1'b0, 1'b1, 8'h00);
      exec(op_none0, mode_reg_direct, 3'h2, 1'b0, 8'h00, 1'b0, 1'b1, 8'h00);
      exec(bit_invert_op, mode_reg_indirect, 3'h4, 1'b0, 8'h10, 1'b0, 1'b0, 8'h00);
      $display("test illegal done");
   endtask

   initial begin
      repeat (3) @(negedge ref_clk);
      srst = 1'b0;
      t_reg_direct();
      t_memory();
      t_reg_bitnum();
      t_write_only();
      t_illegal();
      stop_test();
   end

   // About 140 operations of at most 20 cycles each fit well inside this span
   initial begin
      #800000;
      errors++;
      stop_test();
   end
endmodule
